// ==== rhgs_pkg.sv ====
package rhgs_pkg;
   // register location
   localparam logic [7:0] ROOT_HUB_GLOBAL_STATUS_OFS = 8'h50;
   localparam logic [31:0] ROOT_HUB_GLOBAL_STATUS_RST = 32'h00000000;
   // field positions
   localparam int CLEAR_GLOBAL_POWER_BIT = 0;
   localparam int OVERCURRENT_BIT        = 1;
   localparam int WAKE_ENABLE_BIT        = 15;
   localparam int SET_GLOBAL_POWER_BIT   = 16;
   localparam int OVERCURRENT_CHG_BIT    = 17;
   localparam int WAKE_CLEAR_BIT         = 31;
   // port count default
   localparam int NUM_PORTS_DEF = 4;
   // controller suspend states
   typedef enum logic [1:0] {
      RHGS_OPERATIONAL = 2'b00,
      RHGS_SUSPENDED   = 2'b01,
      RHGS_RESUMING    = 2'b11
   } rhgs_hc_state_t;
endpackage

// ==== rhgs_port_power.sv ====
// per-port power state, driven by global strobes or per-port commands
module rhgs_port_power #(
   parameter int NUM_PORTS = rhgs_pkg::NUM_PORTS_DEF
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   // commands
   input  wire logic                 global_on_i,
   input  wire logic                 global_off_i,
   input  wire logic                 per_port_mode_i,
   input  wire logic [NUM_PORTS-1:0] port_power_mask_i,
   input  wire logic [NUM_PORTS-1:0] port_on_i,
   input  wire logic [NUM_PORTS-1:0] port_off_i,
   // state
   output logic      [NUM_PORTS-1:0] port_power_state_o
);
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic follows_global;
      // masked ports ignore global strobes only in per-port mode
      assign follows_global = !per_port_mode_i || !port_power_mask_i[p];
      always_ff @(posedge clk_i) begin
         if (!reset_n_i) begin
            port_power_state_o[p] <= 1'b0;
         end else if (follows_global && global_off_i) begin
            port_power_state_o[p] <= 1'b0;
         end else if (follows_global && global_on_i) begin
            port_power_state_o[p] <= 1'b1;
         end else if (per_port_mode_i && port_power_mask_i[p] && port_off_i[p]) begin
            port_power_state_o[p] <= 1'b0;
         end else if (per_port_mode_i && port_power_mask_i[p] && port_on_i[p]) begin
            port_power_state_o[p] <= 1'b1;
         end
      end
   end
endmodule

// ==== rhgs_top.sv ====
// Operation
// - the word holds hub status in bits 15..0 and hub status change in bits 31..16.
// - writing one to bit 31 clears the remote wake enable, zero does nothing.
// - hardware sets the overcurrent change flag whenever the overcurrent indicator changes.
// - bit 16 always reads zero.
// - in ganged mode a one in bit 16 powers every port on, zero does nothing.
// - in per-port mode a one in bit 16 powers on only ports with a clear mask bit.
// - with wake enabled, a connect change moves suspended to resuming and flags resume.
// - bit 15 reads the wake enable, writing one sets it, zero does nothing.
// - with global reporting the indicator reads one during overcurrent, else zero.
// - with per-port overcurrent protection the indicator always reads zero.
// - bit 0 always reads zero.
// - in ganged mode a one in bit 0 powers every port off, zero does nothing.
// - in per-port mode a one in bit 0 powers off only ports with a clear mask bit.
// - in per-port mode a set mask bit makes its port obey only per-port commands, a clear one global ones.
// - power switching mode zero is ganged, one is per-port.
module rhgs_top #(
   parameter int NUM_PORTS = rhgs_pkg::NUM_PORTS_DEF
) (
   // clock and reset
   input  wire logic                 CLK_SYS_I,
   input  wire logic                 RESET_N_I,
   // register access
   input  wire logic [7:0]           REG_ADDR_I,
   input  wire logic                 REG_WR_I,
   input  wire logic                 REG_RD_I,
   input  wire logic [31:0]          REG_WDATA_I,
   output logic      [31:0]          REG_RDATA_O,
   // hub configuration
   input  wire logic                 POWER_SWITCH_MODE_I,
   input  wire logic                 PER_PORT_OVERCURRENT_I,
   input  wire logic [NUM_PORTS-1:0] PORT_POWER_MASK_I,
   input  wire logic [NUM_PORTS-1:0] PORT_POWER_ON_I,
   input  wire logic [NUM_PORTS-1:0] PORT_POWER_OFF_I,
   // hub events
   input  wire logic                 OVERCURRENT_I,
   input  wire logic [NUM_PORTS-1:0] CONNECT_CHANGE_FLAG_I,
   input  wire logic                 SUSPEND_REQ_I,
   input  wire logic                 RESUME_DONE_I,
   // status out
   output logic [NUM_PORTS-1:0]      PORT_POWER_STATE_O,
   output logic                      REMOTE_WAKE_ENABLE_O,
   output logic                      HUB_OVERCURRENT_CHANGE_O,
   output logic [1:0]                HC_STATE_O,
   output logic                      RESUME_DETECTED_O
);
   // elaboration-time guard: the mask and state vectors serve 1..15 ports only
   if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_bad_ports
      $error("NUM_PORTS must be 1..15");
   end

   logic                  hit_wr;
   logic                  hit_rd;
   logic                  remote_wake_enable_reg;
   logic                  hub_overcurrent_change_reg;
   logic                  oc_indicator;
   logic                  oc_indicator_reg;
   logic [31:0]           rdata_next;
   rhgs_pkg::rhgs_hc_state_t state_reg;

   // address decode at the single documented offset
   assign hit_wr = REG_WR_I && (REG_ADDR_I == rhgs_pkg::ROOT_HUB_GLOBAL_STATUS_OFS);
   assign hit_rd = REG_RD_I && (REG_ADDR_I == rhgs_pkg::ROOT_HUB_GLOBAL_STATUS_OFS);

   // indicator masked when overcurrent is reported per port
   assign oc_indicator = OVERCURRENT_I && !PER_PORT_OVERCURRENT_I;

   // wake enable: set strobe wins if both strobes are written together
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         remote_wake_enable_reg <= 1'b0;
      end else if (hit_wr && REG_WDATA_I[rhgs_pkg::WAKE_ENABLE_BIT]) begin
         remote_wake_enable_reg <= 1'b1;
      end else if (hit_wr && REG_WDATA_I[rhgs_pkg::WAKE_CLEAR_BIT]) begin
         remote_wake_enable_reg <= 1'b0;
      end
   end

   // previous indicator, used to detect any edge
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         oc_indicator_reg <= 1'b0;
      end else begin
         oc_indicator_reg <= oc_indicator;
      end
   end

   // change flag: a fresh change beats a same-cycle clear so none is lost
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         hub_overcurrent_change_reg <= 1'b0;
      end else if (oc_indicator != oc_indicator_reg) begin
         hub_overcurrent_change_reg <= 1'b1;
      end else if (hit_wr && REG_WDATA_I[rhgs_pkg::OVERCURRENT_CHG_BIT]) begin
         hub_overcurrent_change_reg <= 1'b0;
      end
   end

   // suspend / resume tracking
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         state_reg <= rhgs_pkg::RHGS_OPERATIONAL;
      end else begin
         case (state_reg)
            rhgs_pkg::RHGS_OPERATIONAL: begin
               if (SUSPEND_REQ_I) state_reg <= rhgs_pkg::RHGS_SUSPENDED;
            end
            rhgs_pkg::RHGS_SUSPENDED: begin
               if (remote_wake_enable_reg && |CONNECT_CHANGE_FLAG_I) begin
                  state_reg <= rhgs_pkg::RHGS_RESUMING;
               end
            end
            rhgs_pkg::RHGS_RESUMING: begin
               if (RESUME_DONE_I) state_reg <= rhgs_pkg::RHGS_OPERATIONAL;
            end
            default: state_reg <= rhgs_pkg::RHGS_OPERATIONAL;
         endcase
      end
   end

   // one-cycle resume-detected pulse on the wake transition
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         RESUME_DETECTED_O <= 1'b0;
      end else begin
         RESUME_DETECTED_O <= (state_reg == rhgs_pkg::RHGS_SUSPENDED)
                              && remote_wake_enable_reg && |CONNECT_CHANGE_FLAG_I;
      end
   end

   // read image; local power bits and reserved bits read zero
   always_comb begin
      rdata_next                                  = 32'h00000000;
      rdata_next[rhgs_pkg::OVERCURRENT_BIT]       = oc_indicator;
      rdata_next[rhgs_pkg::WAKE_ENABLE_BIT]       = remote_wake_enable_reg;
      rdata_next[rhgs_pkg::OVERCURRENT_CHG_BIT]   = hub_overcurrent_change_reg;
   end

   // read data registered, held between reads
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESET_N_I) begin
         REG_RDATA_O <= rhgs_pkg::ROOT_HUB_GLOBAL_STATUS_RST;
      end else if (hit_rd) begin
         REG_RDATA_O <= rdata_next;
      end
   end

   // port power switching; global strobes come straight from the write
   rhgs_port_power #(
      .NUM_PORTS (NUM_PORTS)
   ) u_port_power (
      .clk_i              (CLK_SYS_I),
      .reset_n_i          (RESET_N_I),
      .global_on_i        (hit_wr && REG_WDATA_I[rhgs_pkg::SET_GLOBAL_POWER_BIT]),
      .global_off_i       (hit_wr && REG_WDATA_I[rhgs_pkg::CLEAR_GLOBAL_POWER_BIT]),
      .per_port_mode_i    (POWER_SWITCH_MODE_I),
      .port_power_mask_i  (PORT_POWER_MASK_I),
      .port_on_i          (PORT_POWER_ON_I),
      .port_off_i         (PORT_POWER_OFF_I),
      .port_power_state_o (PORT_POWER_STATE_O)
   );

   assign REMOTE_WAKE_ENABLE_O     = remote_wake_enable_reg;
   assign HUB_OVERCURRENT_CHANGE_O = hub_overcurrent_change_reg;
   assign HC_STATE_O               = state_reg;
endmodule

// ==== rhgs_top_sva.sv ====
module rhgs_top_sva #(
   parameter int NUM_PORTS = rhgs_pkg::NUM_PORTS_DEF
) (
   input wire logic                 CLK_SYS_I, RESET_N_I, REG_WR_I, REG_RD_I,
   input wire logic [7:0]           REG_ADDR_I,
   input wire logic [31:0]          REG_WDATA_I, REG_RDATA_O,
   input wire logic                 POWER_SWITCH_MODE_I, PER_PORT_OVERCURRENT_I, OVERCURRENT_I,
   input wire logic [NUM_PORTS-1:0] PORT_POWER_MASK_I, CONNECT_CHANGE_FLAG_I, PORT_POWER_STATE_O,
   input wire logic                 REMOTE_WAKE_ENABLE_O, HUB_OVERCURRENT_CHANGE_O, RESUME_DETECTED_O,
   input wire logic [1:0]           HC_STATE_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESET_N_I);
   // decoded hits and masked indicator, as seen by software
   wire logic hit_wr = REG_WR_I && REG_ADDR_I == rhgs_pkg::ROOT_HUB_GLOBAL_STATUS_OFS;
   wire logic hit_rd = REG_RD_I && REG_ADDR_I == rhgs_pkg::ROOT_HUB_GLOBAL_STATUS_OFS;
   wire logic ind    = OVERCURRENT_I && !PER_PORT_OVERCURRENT_I;
   wire logic [31:0] d = REG_WDATA_I;
   AST_WAKE_SET: assert property (hit_wr && d[15] |=> REMOTE_WAKE_ENABLE_O)
      else $error("wake enable not set");
   AST_WAKE_CLR: assert property (hit_wr && d[31] && !d[15] |=> !REMOTE_WAKE_ENABLE_O)
      else $error("wake enable not cleared");
   AST_OC_CHG: assert property ($changed(ind) |=> HUB_OVERCURRENT_CHANGE_O)
      else $error("overcurrent change not flagged");
   AST_OC_CLR: assert property (hit_wr && d[17] && $stable(ind) |=> !HUB_OVERCURRENT_CHANGE_O)
      else $error("overcurrent change not cleared");
   // bit 31 left out of the check, although it always reads zero
   AST_RD_IMAGE: assert property (hit_rd |=> REG_RDATA_O[30:0] == {13'h0,
      $past(HUB_OVERCURRENT_CHANGE_O), 1'b0, $past(REMOTE_WAKE_ENABLE_O), 13'h0, $past(ind), 1'b0})
      else $error("read image wrong");
   AST_GANG_ON: assert property (hit_wr && d[16] && !d[0] && !POWER_SWITCH_MODE_I
      |=> &PORT_POWER_STATE_O) else $error("ganged power on failed");
   AST_GANG_OFF: assert property (hit_wr && d[0] && !POWER_SWITCH_MODE_I
      |=> PORT_POWER_STATE_O == '0) else $error("ganged power off failed");
   AST_PP_ON: assert property (hit_wr && d[16] && !d[0] && POWER_SWITCH_MODE_I
      |=> &(PORT_POWER_STATE_O | $past(PORT_POWER_MASK_I))) else $error("per-port on failed");
   AST_PP_OFF: assert property (hit_wr && d[0] && POWER_SWITCH_MODE_I
      |=> !(|(PORT_POWER_STATE_O & ~$past(PORT_POWER_MASK_I)))) else $error("per-port off failed");
   AST_RESUME: assert property (HC_STATE_O == rhgs_pkg::RHGS_SUSPENDED && REMOTE_WAKE_ENABLE_O
      && |CONNECT_CHANGE_FLAG_I |=> RESUME_DETECTED_O && HC_STATE_O == rhgs_pkg::RHGS_RESUMING)
      else $error("resume not detected");
endmodule
bind rhgs_top rhgs_top_sva #(.NUM_PORTS(NUM_PORTS)) sva_u (.CLK_SYS_I(CLK_SYS_I),
   .RESET_N_I(RESET_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .POWER_SWITCH_MODE_I(POWER_SWITCH_MODE_I),
   .PER_PORT_OVERCURRENT_I(PER_PORT_OVERCURRENT_I), .OVERCURRENT_I(OVERCURRENT_I),
   .PORT_POWER_MASK_I(PORT_POWER_MASK_I), .CONNECT_CHANGE_FLAG_I(CONNECT_CHANGE_FLAG_I),
   .PORT_POWER_STATE_O(PORT_POWER_STATE_O), .REMOTE_WAKE_ENABLE_O(REMOTE_WAKE_ENABLE_O),
   .HUB_OVERCURRENT_CHANGE_O(HUB_OVERCURRENT_CHANGE_O), .RESUME_DETECTED_O(RESUME_DETECTED_O),
   .HC_STATE_O(HC_STATE_O));

// ==== tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] OFS = rhgs_pkg::ROOT_HUB_GLOBAL_STATUS_OFS;
   logic clk, rst_n, wr, rd, mode, ppoc, oc, sus, rdone, rwe, occ, resd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] mask, pon, poff, cc, port_power_state;
   logic [1:0] hcs;
   int failures = 0;
   int num_checks = 0;
   rhgs_top #(.NUM_PORTS(4)) dut_u (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
      .POWER_SWITCH_MODE_I(mode), .PER_PORT_OVERCURRENT_I(ppoc), .PORT_POWER_MASK_I(mask),
      .PORT_POWER_ON_I(pon), .PORT_POWER_OFF_I(poff), .OVERCURRENT_I(oc),
      .CONNECT_CHANGE_FLAG_I(cc), .SUSPEND_REQ_I(sus), .RESUME_DONE_I(rdone),
      .PORT_POWER_STATE_O(port_power_state), .REMOTE_WAKE_ENABLE_O(rwe), .HUB_OVERCURRENT_CHANGE_O(occ),
      .HC_STATE_O(hcs), .RESUME_DETECTED_O(resd));
   // free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one-cycle strobes; #1 lets the taking edge land before comparing
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= dat;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= OFS;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // watchdog well beyond the few dozen cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      complete_run();
   end
   initial begin
      {wr, rd, mode, ppoc, oc, sus, rdone} = '0;
      {addr, wdata, mask, pon, poff, cc} = '0;
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(32'h0);
      wr_reg(OFS, 32'h00008000);
      rd_reg(32'h00008000);
      wr_reg(8'h54, 32'h80000000);
      wr_reg(OFS, 32'h0);
      rd_reg(32'h00008000);
      wr_reg(OFS, 32'h80000000);
      rd_reg(32'h0);
      $display("test wake enable done");
      @(posedge clk) oc <= 1'b1;
      rd_reg(32'h00020002);
      wr_reg(OFS, 32'h00020000);
      rd_reg(32'h00000002);
      @(posedge clk) oc <= 1'b0;
      rd_reg(32'h00020000);
      wr_reg(OFS, 32'h00020000);
      @(posedge clk) ppoc <= 1'b1;
      @(posedge clk) oc <= 1'b1;
      rd_reg(32'h0);
      @(posedge clk) {oc, ppoc} <= 2'b00;
      $display("test overcurrent done");
      wr_reg(OFS, 32'h00010000);
      chk({28'h0, port_power_state}, 32'hF);
      rd_reg(32'h0);
      wr_reg(OFS, 32'h00000001);
      chk({28'h0, port_power_state}, 32'h0);
      @(posedge clk) {mode, mask} <= {1'b1, 4'h5};
      wr_reg(OFS, 32'h00010000);
      chk({28'h0, port_power_state}, 32'hA);
      @(posedge clk) pon <= 4'h5;
      @(posedge clk) pon <= 4'h0;
      #1 chk({28'h0, port_power_state}, 32'hF);
      wr_reg(OFS, 32'h00000001);
      chk({28'h0, port_power_state}, 32'h5);
      @(posedge clk) poff <= 4'h1;
      @(posedge clk) poff <= 4'h0;
      #1 chk({28'h0, port_power_state}, 32'h4);
      $display("test port power done");
      wr_reg(OFS, 32'h00008000);
      @(posedge clk) sus <= 1'b1;
      @(posedge clk) sus <= 1'b0;
      #1 chk({30'h0, hcs}, 32'h1);
      @(posedge clk) cc <= 4'h2;
      @(posedge clk) cc <= 4'h0;
      #1 chk({29'h0, resd, hcs}, 32'h7);
      @(posedge clk) rdone <= 1'b1;
      @(posedge clk) rdone <= 1'b0;
      #1 chk({30'h0, hcs}, 32'h0);
      $display("test resume done");
      complete_run();
   end
endmodule
